// ==== src/bcr_pkg.sv ====
// constants, register map and decode helpers for the boost and current config bank
package bcr_pkg;
   // register offsets
   localparam logic [7:0] ADDR_EMI_SHAPING   = 8'h00;
   localparam logic [7:0] ADDR_BOOST_FREQ    = 8'h01;
   localparam logic [7:0] ADDR_CHANNEL_CODE  = 8'h02;
   // reset values
   localparam logic [7:0] RST_EMI_SHAPING    = 8'h6b;
   localparam logic [7:0] RST_BOOST_FREQ     = 8'h17;
   localparam logic [7:0] RST_CHANNEL_CODE   = 8'h82;
   // writable field masks; other bits keep their reset value
   localparam logic [7:0] MASK_EMI_SHAPING   = 8'he0;
   localparam logic [7:0] MASK_BOOST_FREQ    = 8'h1f;
   localparam logic [7:0] MASK_CHANNEL_CODE  = 8'hff;
   // field positions
   localparam int SS_BIT      = 7;
   localparam int EDGE_HI     = 6;
   localparam int EDGE_LO     = 5;
   localparam int ILIM_BIT    = 4;
   localparam int FREQ_HI     = 3;
   localparam int FREQ_LO     = 0;
   // edge rate percentages of nominal slew
   localparam logic [7:0] EDGE_PCT_00 = 8'h19;   // 25
   localparam logic [7:0] EDGE_PCT_01 = 8'h32;   // 50
   localparam logic [7:0] EDGE_PCT_10 = 8'h64;   // 100
   localparam logic [7:0] EDGE_PCT_11 = 8'hc8;   // 200
   // current limit thresholds in mA
   localparam logic [11:0] ILIM_LOW_MA  = 12'h5dc;  // 1500
   localparam logic [11:0] ILIM_HIGH_MA = 12'h9c4;  // 2500
   // channel current in units of 10 uA
   localparam logic [7:0]  CODE_ZERO       = 8'h00;
   localparam logic [7:0]  CODE_CLAMP_TOP  = 8'h2f;
   localparam logic [7:0]  CODE_FULL       = 8'hff;
   localparam logic [11:0] CUR_ZERO        = 12'h000;
   localparam logic [11:0] CUR_MIN         = 12'h3ec;  // 10.04 mA
   localparam logic [11:0] CUR_FULL        = 12'hdac;  // 35.00 mA
   localparam logic [11:0] CUR_STEP        = 12'h00c;  // 0.12 mA
   localparam int          NUM_CHANNELS    = 6;
   // clock and switching period
   localparam int CLK_KHZ  = 100000;
   localparam int PER_W    = 9;
   localparam logic [7:0]  LFSR_SEED  = 8'h5a;
   localparam logic [3:0]  DITHER_OFF = 4'h0;
   localparam logic [PER_W-1:0] PER_ONE = 9'h001;

   // switching frequency in kHz for each 4-bit code
   function automatic int freq_khz(input logic [3:0] code);
      case (code)
         4'h5:    freq_khz = 400;
         4'h6:    freq_khz = 500;
         4'h7:    freq_khz = 600;
         4'h8:    freq_khz = 700;
         4'h9:    freq_khz = 800;
         4'ha:    freq_khz = 900;
         4'hb:    freq_khz = 1000;
         4'hc:    freq_khz = 1225;
         4'hd:    freq_khz = 1335;
         4'he:    freq_khz = 1450;
         4'hf:    freq_khz = 1600;
         default: freq_khz = 300;
      endcase
   endfunction

   // period in clock cycles, rounded down
   function automatic logic [PER_W-1:0] freq_period(input logic [3:0] code);
      int p;
      p = CLK_KHZ / freq_khz(code);
      freq_period = p[PER_W-1:0];
   endfunction
endpackage

// ==== src/bcr_sw_if.sv ====
// signals between the config bank and the power switch timing module
`timescale 1ns/1ns
interface bcr_sw_if;
   logic [8:0]  period;
   logic        ss_en;
   logic        switch_on;
   logic        cycle_start;
   modport cfg (output period, output ss_en, input switch_on, input cycle_start);
   modport sw  (input period, input ss_en, output switch_on, output cycle_start);
endinterface

// ==== src/bcr_switch_ctl.sv ====
// switching oscillator with spread spectrum and peak current cutoff
`timescale 1ns/1ns
module bcr_switch_ctl (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic peak_over_limit,
   bcr_sw_if.sw      sw
);
   logic [8:0] cnt_reg;
   logic [8:0] per_reg;
   logic [7:0] lfsr_reg;
   logic       s1_reg;
   logic       s2_reg;
   logic       s3_reg;
   logic       over_reg;
   logic       on_reg;
   logic       start_reg;

   // wrap on the last count; a zero period right after reset wraps at once instead of running 512 clocks
   wire        wrap       = (cnt_reg + bcr_pkg::PER_ONE >= per_reg);
   wire [3:0]  dither     = sw.ss_en ? lfsr_reg[3:0] : bcr_pkg::DITHER_OFF;
   wire [8:0]  per_next   = sw.period + {5'h00, dither};
   wire        lfsr_fb    = lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3];

   // comparator comes from the analog side, so three flops; level moves on agreement
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_reg   <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         over_reg <= 1'b0;
      end else begin
         s1_reg <= peak_over_limit;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            over_reg <= s3_reg;
         end
      end
   end

   // period counter; dither is picked once per period so each cycle is whole
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg   <= '0;
         per_reg   <= bcr_pkg::PER_ONE;
         lfsr_reg  <= bcr_pkg::LFSR_SEED;
         start_reg <= 1'b0;
      end else begin
         start_reg <= wrap;
         if (wrap) begin
            cnt_reg  <= '0;
            per_reg  <= per_next;
            lfsr_reg <= {lfsr_reg[6:0], lfsr_fb};
         end else begin
            cnt_reg <= cnt_reg + bcr_pkg::PER_ONE;
         end
      end
   end

   // switch on at each period start, off once peak current passes the limit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         on_reg <= 1'b0;
      end else if (start_reg) begin
         on_reg <= 1'b1;
      end else if (over_reg) begin
         on_reg <= 1'b0;
      end
   end

   assign sw.switch_on   = on_reg;
   assign sw.cycle_start = start_reg;
endmodule

// ==== src/bcr_config_bank.sv ====
// boost converter and channel current configuration register bank
// What this block does
// - edge rate field bits 6:5 of reg 0 select 25/50/100/200 percent, reset 11.
// - bit 7 of reg 0 enables spread spectrum, resets to 0.
// - frequency codes 0 to 4 give 300 kHz, code F gives 1600 kHz.
// - codes 5 to B step 400 to 1000 kHz; C, D, E give 1225/1335/1450.
// - bit 4 of reg 1 selects 1.5 A or 2.5 A limit, reset 2.5 A.
// - switch turns off past the peak limit until next oscillator on-phase.
// - current code 0x00 means zero channel current.
// - codes 0x01 to 0x2F all give 10.04 mA.
// - above 0x2F current rises 0.12 mA per code, 35 mA at 0xFF.
// - current code register resets to 0x82, which is 20 mA.
// - current code is one full-scale maximum shared by all channels.
`timescale 1ns/1ns
module bcr_config_bank (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        peak_over_limit,
   output logic             switch_on,
   output logic             ss_en,
   output logic      [1:0]  edge_rate_code,
   output logic      [7:0]  edge_rate_pct,
   output logic      [8:0]  switch_period,
   output logic      [11:0] current_limit_ma,
   output logic      [11:0] channel_current [bcr_pkg::NUM_CHANNELS]
);
   logic [7:0]  emi_shaping_and_dim_control_reg;
   logic [7:0]  boost_frequency_and_limit_reg;
   logic [7:0]  channel_max_current_code_reg;
   logic [7:0]  rdata_reg;
   logic [1:0]  edge_reg;
   logic [7:0]  edge_pct_reg;
   logic        ss_reg;
   logic [8:0]  period_reg;
   logic [11:0] ilim_reg;
   logic [11:0] cur_reg;

   bcr_sw_if sw_bus ();

   // address decode
   wire hit_emi  = (reg_addr == bcr_pkg::ADDR_EMI_SHAPING);
   wire hit_freq = (reg_addr == bcr_pkg::ADDR_BOOST_FREQ);
   wire hit_code = (reg_addr == bcr_pkg::ADDR_CHANNEL_CODE);

   // masked write values; reserved bits are forced back to reset value
   wire [7:0] emi_next  = (reg_wdata & bcr_pkg::MASK_EMI_SHAPING)
                        | (bcr_pkg::RST_EMI_SHAPING & ~bcr_pkg::MASK_EMI_SHAPING);
   wire [7:0] freq_next = (reg_wdata & bcr_pkg::MASK_BOOST_FREQ)
                        | (bcr_pkg::RST_BOOST_FREQ & ~bcr_pkg::MASK_BOOST_FREQ);
   wire [7:0] code_next = reg_wdata & bcr_pkg::MASK_CHANNEL_CODE;

   // read mux; unmapped offsets read as zero
   wire [7:0] rd_mux = hit_emi  ? emi_shaping_and_dim_control_reg :
                       hit_freq ? boost_frequency_and_limit_reg :
                       hit_code ? channel_max_current_code_reg : 8'h00;

   // field extraction
   wire [1:0] edge_field = emi_shaping_and_dim_control_reg[bcr_pkg::EDGE_HI:bcr_pkg::EDGE_LO];
   wire       ss_field   = emi_shaping_and_dim_control_reg[bcr_pkg::SS_BIT];
   wire       ilim_field = boost_frequency_and_limit_reg[bcr_pkg::ILIM_BIT];
   wire [3:0] freq_field = boost_frequency_and_limit_reg[bcr_pkg::FREQ_HI:bcr_pkg::FREQ_LO];
   wire [7:0] code       = channel_max_current_code_reg;

   // edge rate decode
   wire [7:0] edge_pct_next = (edge_field == 2'h0) ? bcr_pkg::EDGE_PCT_00 :
                              (edge_field == 2'h1) ? bcr_pkg::EDGE_PCT_01 :
                              (edge_field == 2'h2) ? bcr_pkg::EDGE_PCT_10 :
                                                     bcr_pkg::EDGE_PCT_11;

   // frequency code to period in clock cycles
   wire [8:0] period_next = bcr_pkg::freq_period(freq_field);

   // peak limit threshold handed to the current comparator
   wire [11:0] ilim_next = ilim_field ? bcr_pkg::ILIM_HIGH_MA : bcr_pkg::ILIM_LOW_MA;

   // current code to 10 uA units: full scale minus 12 per code below 0xff
   wire [7:0]  code_gap   = bcr_pkg::CODE_FULL - code;
   wire [11:0] gap_cur    = 12'(code_gap) * bcr_pkg::CUR_STEP;
   wire [11:0] lin_cur    = bcr_pkg::CUR_FULL - gap_cur;
   wire [11:0] cur_next   = (code == bcr_pkg::CODE_ZERO)      ? bcr_pkg::CUR_ZERO :
                            (code <= bcr_pkg::CODE_CLAMP_TOP) ? bcr_pkg::CUR_MIN :
                                                                lin_cur;

   // register writes from the serial interface engine
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         emi_shaping_and_dim_control_reg <= bcr_pkg::RST_EMI_SHAPING;
         boost_frequency_and_limit_reg   <= bcr_pkg::RST_BOOST_FREQ;
         channel_max_current_code_reg    <= bcr_pkg::RST_CHANNEL_CODE;
      end else if (reg_wr) begin
         if (hit_emi) begin
            emi_shaping_and_dim_control_reg <= emi_next;
         end else if (hit_freq) begin
            boost_frequency_and_limit_reg <= freq_next;
         end else if (hit_code) begin
            channel_max_current_code_reg <= code_next;
         end
      end
   end

   // read data held until the next read
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= rd_mux;
      end
   end

   // decoded settings registered so outputs come from flops; one cycle behind the field
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         edge_reg     <= 2'h0;
         edge_pct_reg <= 8'h00;
         ss_reg       <= 1'b0;
         period_reg   <= 9'h000;
         ilim_reg     <= 12'h000;
         cur_reg      <= 12'h000;
      end else begin
         edge_reg     <= edge_field;
         edge_pct_reg <= edge_pct_next;
         ss_reg       <= ss_field;
         period_reg   <= period_next;
         ilim_reg     <= ilim_next;
         cur_reg      <= cur_next;
      end
   end

   // same full-scale value drives every channel sink; brightness scaling is downstream
   genvar ch;
   generate
      for (ch = 0; ch < bcr_pkg::NUM_CHANNELS; ch++) begin : g_chan
         assign channel_current[ch] = cur_reg;
      end
   endgenerate

   assign sw_bus.period = period_reg;
   assign sw_bus.ss_en  = ss_reg;

   bcr_switch_ctl u_switch (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .peak_over_limit (peak_over_limit),
      .sw              (sw_bus.sw)
   );

   // outputs
   assign reg_rdata        = rdata_reg;
   assign switch_on        = sw_bus.switch_on;
   assign ss_en            = ss_reg;
   assign edge_rate_code   = edge_reg;
   assign edge_rate_pct    = edge_pct_reg;
   assign switch_period    = period_reg;
   assign current_limit_ma = ilim_reg;
endmodule

// ==== bench/bcr_config_bank_sva.sv ====
// port checker for the config bank
`timescale 1ns/1ns
module bcr_config_bank_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        peak_over_limit,
   input wire logic        switch_on,
   input wire logic        ss_en,
   input wire logic [1:0]  edge_rate_code,
   input wire logic [7:0]  edge_rate_pct,
   input wire logic [8:0]  switch_period,
   input wire logic [11:0] current_limit_ma,
   input wire logic [11:0] channel_current [bcr_pkg::NUM_CHANNELS]
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // write strobes per register
   wire w0 = reg_wr && reg_addr == bcr_pkg::ADDR_EMI_SHAPING;
   wire w1 = reg_wr && reg_addr == bcr_pkg::ADDR_BOOST_FREQ;
   wire w2 = reg_wr && reg_addr == bcr_pkg::ADDR_CHANNEL_CODE;
   wire [7:0] pct_x = edge_rate_code[1] ? (edge_rate_code[0] ? 8'hc8 : 8'h64) : (edge_rate_code[0] ? 8'h32 : 8'h19);
   // expected current in 10 uA units, kept apart from the design's own decode
   function automatic logic [11:0] cur_f(input logic [7:0] c);
      if (c == 8'h00)
         return 12'h000;
      if (c <= 8'h2f)
         return 12'h3ec;
      return 12'hdac - 12'h00c * (12'h0ff - {4'h0, c});
   endfunction
   property p_edge; w0 |-> ##2 edge_rate_code == $past(reg_wdata[6:5], 2); endproperty
   a_edge: assert property (p_edge) else $error("edge code wrong");
   property p_pct; !$past(rst) |-> edge_rate_pct == pct_x; endproperty
   a_pct: assert property (p_pct) else $error("edge percent wrong");
   property p_ss; w0 |-> ##2 ss_en == $past(reg_wdata[7], 2); endproperty
   a_ss: assert property (p_ss) else $error("spread enable wrong");
   property p_lim; w1 |-> ##2 current_limit_ma == ($past(reg_wdata[4], 2) ? 12'h9c4 : 12'h5dc); endproperty
   a_lim: assert property (p_lim) else $error("limit wrong");
   property p_cur; w2 |-> ##2 channel_current[0] == cur_f($past(reg_wdata, 2)); endproperty
   a_cur: assert property (p_cur) else $error("current wrong");
   property p_same;
      !$past(rst) |-> channel_current[1] == channel_current[0] && channel_current[5] == channel_current[0];
   endproperty
   a_same: assert property (p_same) else $error("channels differ");
   property p_cut; $rose(peak_over_limit) && switch_on |-> ##[1:8] !switch_on; endproperty
   a_cut: assert property (p_cut) else $error("switch not cut");
   property p_unmap; reg_rd && reg_addr > 8'h02 |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_resv; reg_rd && reg_addr == 8'h00 |=> reg_rdata[4:0] == 5'h0b; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits changed");
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   c_cur: cover property (w2);
   c_cut: cover property (switch_on ##1 !switch_on);
   c_unmap: cover property (reg_rd && reg_addr > 8'h02);
endmodule
bind bcr_config_bank bcr_config_bank_sva bcr_config_bank_sva_i (
   .sys_clk          (sys_clk),
   .rst              (rst),
   .reg_addr         (reg_addr),
   .reg_wr           (reg_wr),
   .reg_wdata        (reg_wdata),
   .reg_rd           (reg_rd),
   .reg_rdata        (reg_rdata),
   .peak_over_limit  (peak_over_limit),
   .switch_on        (switch_on),
   .ss_en            (ss_en),
   .edge_rate_code   (edge_rate_code),
   .edge_rate_pct    (edge_rate_pct),
   .switch_period    (switch_period),
   .current_limit_ma (current_limit_ma),
   .channel_current  (channel_current)
);

// ==== bench/bcr_host_model.sv ====
// host model issuing register strobes
`timescale 1ns/1ns
module bcr_host_model (
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // idle lines flip after use so a stale value never looks valid
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // write held for the one edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      reg_addr <= ~a;
   endtask
   // read data is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the config bank
`timescale 1ns/1ns
module tb_top;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        peak_over_limit = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
   logic        reg_wr, reg_rd, switch_on, ss_en;
   logic [1:0]  edge_rate_code;
   logic [7:0]  edge_rate_pct;
   logic [8:0]  switch_period;
   logic [11:0] current_limit_ma;
   logic [11:0] channel_current [bcr_pkg::NUM_CHANNELS];
   int          err_count = 0;
   int          samples_checked = 0;
   // expected periods, percents and currents per code
   localparam logic [8:0] per_t [16] = '{9'h14d, 9'h14d, 9'h14d, 9'h14d, 9'h14d, 9'h0fa, 9'h0c8, 9'h0a6,
                                         9'h08e, 9'h07d, 9'h06f, 9'h064, 9'h051, 9'h04a, 9'h044, 9'h03e};
   localparam logic [7:0] pct_t [4]  = '{8'h19, 8'h32, 8'h64, 8'hc8};
   localparam logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h2f, 8'h30, 8'h82, 8'hff};
   localparam logic [11:0] cur_e [6] = '{12'h000, 12'h3ec, 12'h3ec, 12'h3f8, 12'h7d0, 12'hdac};
   always #5 sys_clk = ~sys_clk;
   bcr_config_bank bcr_config_bank_i (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .reg_addr         (reg_addr),
      .reg_wr           (reg_wr),
      .reg_wdata        (reg_wdata),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .peak_over_limit  (peak_over_limit),
      .switch_on        (switch_on),
      .ss_en            (ss_en),
      .edge_rate_code   (edge_rate_code),
      .edge_rate_pct    (edge_rate_pct),
      .switch_period    (switch_period),
      .current_limit_ma (current_limit_ma),
      .channel_current  (channel_current)
   );
   bcr_host_model bcr_host_model_i (
      .sys_clk   (sys_clk),
      .reg_addr  (reg_addr),
      .reg_wr    (reg_wr),
      .reg_wdata (reg_wdata),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata)
   );
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // decoded outputs land one edge after the register
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_reset;
      bcr_host_model_i.rd(8'h00, rv);
      chk("reg0", 12'h06b, {4'h0, rv});
      bcr_host_model_i.rd(8'h01, rv);
      chk("reg1", 12'h017, {4'h0, rv});
      bcr_host_model_i.rd(8'h02, rv);
      chk("reg2", 12'h082, {4'h0, rv});
      chk("pct", 12'h0c8, {4'h0, edge_rate_pct});
      chk("ss", 12'h000, {11'h0, ss_en});
      chk("per", 12'h0a6, {3'h0, switch_period});
      chk("lim", 12'h9c4, current_limit_ma);
      chk("cur", 12'h7d0, channel_current[0]);
   endtask
   // low bits are written as ones and must stay at reset value
   task automatic t_edge;
      for (int c = 0; c < 4; c++) begin
         bcr_host_model_i.wr(8'h00, {c[0], c[1:0], 5'h1f});
         settle;
         chk("pct", {4'h0, pct_t[c]}, {4'h0, edge_rate_pct});
         chk("edge", {10'h0, c[1:0]}, {10'h0, edge_rate_code});
         chk("ss", {11'h0, c[0]}, {11'h0, ss_en});
         bcr_host_model_i.rd(8'h00, rv);
         chk("reg0", {4'h0, c[0], c[1:0], 5'h0b}, {4'h0, rv});
      end
   endtask
   task automatic t_freq;
      for (int c = 0; c < 16; c++) begin
         bcr_host_model_i.wr(8'h01, {3'h7, c[0], c[3:0]});
         settle;
         chk("per", {3'h0, per_t[c]}, {3'h0, switch_period});
         chk("lim", c[0] ? 12'h9c4 : 12'h5dc, current_limit_ma);
         bcr_host_model_i.rd(8'h01, rv);
         chk("reg1", {7'h0, c[0], c[3:0]}, {4'h0, rv});
      end
   endtask
   task automatic t_cur;
      for (int i = 0; i < 6; i++) begin
         bcr_host_model_i.wr(8'h02, codes[i]);
         settle;
         for (int k = 0; k < bcr_pkg::NUM_CHANNELS; k++)
            chk("cur", cur_e[i], channel_current[k]);
      end
   endtask
   task automatic t_unmap;
      bcr_host_model_i.wr(8'h03, 8'h55);
      bcr_host_model_i.rd(8'h03, rv);
      chk("unmapped", 12'h000, {4'h0, rv});
      bcr_host_model_i.rd(8'h02, rv);
      chk("reg2", 12'h0ff, {4'h0, rv});
   endtask
   // wait for the gate to reach a level, looked at just after each edge
   task automatic wait_lvl(input logic v);
      for (int n = 0; n < 400 && switch_on !== v; n++) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   // phase is taken from a fresh turn-on so no period start can fall inside a check
   task automatic t_switch;
      @(posedge sys_clk);
      peak_over_limit <= 1'b1;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      chk("start", 12'h001, {11'h0, switch_on});
      @(posedge sys_clk);
      #1;
      chk("cut", 12'h000, {11'h0, switch_on});
      @(posedge sys_clk);
      peak_over_limit <= 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      chk("held", 12'h000, {11'h0, switch_on});
      wait_lvl(1'b1);
      chk("restart", 12'h001, {11'h0, switch_on});
      repeat (3) @(posedge sys_clk);
      peak_over_limit <= 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
      chk("midcut", 12'h000, {11'h0, switch_on});
      @(posedge sys_clk);
      peak_over_limit <= 1'b0;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_edge;
      t_freq;
      t_cur;
      t_unmap;
      t_switch;
      results;
   end
   // run needs well under a thousand cycles; cut any hang at ten thousand
   initial begin
      #100000;
      err_count++;
      results;
   end
endmodule
